// [logic/nvm_i2c_target.sv]
`timescale 1ns/100ps
// serial byte memory target with apb control and status
module nvm_i2c_target #(
  parameter logic [3:0] DEV_TYPE  = nvm_pkg::DEV_TYPE_DEF, // arbitrary value
  parameter int         MEM_DEPTH = nvm_pkg::MEM_DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        wp_i
);
  localparam int AW = nvm_pkg::ADDR_W;
  localparam int DW = nvm_pkg::DATA_W;

  // -----------------------------------------------------------------
  // elaboration checks
  // -----------------------------------------------------------------
  if (MEM_DEPTH != (1 << AW)) begin : g_bad_depth
    $error("memory depth must match the 11-bit address");
  end
  if (nvm_pkg::SCL_MIN_CYC < nvm_pkg::SCL_NEED_CYC) begin : g_bad_rate
    $error("core clock too slow to oversample the serial clock");
  end

  nvm_pkg::state_e      state_r;
  logic [3:0]           bit_cnt_r;
  logic [DW-1:0]        rx_r;
  logic [DW-1:0]        tx_r;
  logic [AW-1:0]        addr_r;
  logic                 rw_r;
  logic                 ack_r;
  logic                 sda_oe_r;
  logic                 sda_o_r;
  logic [1:0]           ctrl_r;
  logic [nvm_pkg::CNT_W-1:0] cnt_r;
  logic                 pready_r;
  logic                 pslverr_r;
  logic [31:0]          prdata_r;
  logic [2:0]           pins_s;
  logic                 scl_s;
  logic                 sda_s;
  logic                 wp_s;
  logic                 scl_q;
  logic                 sda_q;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_det;
  logic                 stop_det;
  logic                 rx_state;
  logic                 rx_end;
  logic                 tx_end;
  logic                 tx_load;
  logic                 dev_hit;
  logic                 wp_eff;
  logic                 wr_commit;
  logic [DW-1:0]        mem_rdata;
  logic [31:0]          status_w;

  // -----------------------------------------------------------------
  // pin sampling and bus conditions
  // -----------------------------------------------------------------
  // pins pass two flops; reset loads wp low, but nothing pulls an open wp pin low [R7]
  bit_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h6)
  ) u_pin_sync (
    .clk  (core_clk),
    .rst  (rst),
    .din  ({scl_i, sda_i, wp_i}),
    .dout (pins_s)
  );
  assign scl_s = pins_s[2];
  assign sda_s = pins_s[1];
  assign wp_s  = pins_s[0];

  // previous levels for edge detection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // oversampling at core rate serves every bus speed up to 1 MHz [R8]
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  // byte framing shared by the processes below
  assign rx_state  = (state_r == nvm_pkg::ST_ADDR) || (state_r == nvm_pkg::ST_WORD) ||
                     (state_r == nvm_pkg::ST_WDATA);
  assign rx_end    = rx_state && scl_fall && (bit_cnt_r == nvm_pkg::BYTE_BITS);
  assign tx_end    = (state_r == nvm_pkg::ST_RDATA) && scl_fall &&
                     (bit_cnt_r == nvm_pkg::BYTE_BITS);
  assign tx_load   = scl_fall && (((state_r == nvm_pkg::ST_ACK_DEV) && rw_r) ||
                     ((state_r == nvm_pkg::ST_RACK) && ack_r));
  assign dev_hit   = (rx_r[7:nvm_pkg::TYPE_LSB] == DEV_TYPE) && ctrl_r[nvm_pkg::CTRL_EN];
  assign wp_eff    = wp_s | ctrl_r[nvm_pkg::CTRL_SWP];
  assign wr_commit = rx_end && (state_r == nvm_pkg::ST_WDATA) && !wp_eff; // [R2] [R6]

  // -----------------------------------------------------------------
  // serial engine
  // -----------------------------------------------------------------
  // state, bit count and the open-drain enable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r   <= nvm_pkg::ST_IDLE; // [R10]
      bit_cnt_r <= 4'h0;
      sda_oe_r  <= 1'b0;
    end else if (start_det) begin
      state_r   <= nvm_pkg::ST_ADDR; // [R3]
      bit_cnt_r <= 4'h0;
      sda_oe_r  <= 1'b0;
    end else if (stop_det) begin
      state_r   <= nvm_pkg::ST_IDLE;
      sda_oe_r  <= 1'b0;
    end else begin
      case (state_r)
        nvm_pkg::ST_ADDR, nvm_pkg::ST_WORD, nvm_pkg::ST_WDATA: begin
          if (scl_rise && bit_cnt_r != nvm_pkg::BYTE_BITS) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          if (rx_end) begin
            bit_cnt_r <= 4'h0;
            if (state_r == nvm_pkg::ST_ADDR && !dev_hit) begin
              state_r <= nvm_pkg::ST_IDLE;
            end else begin
              sda_oe_r <= 1'b1; // acknowledge, even when protected [R9]
              state_r  <= (state_r == nvm_pkg::ST_ADDR) ? nvm_pkg::ST_ACK_DEV :
                          (state_r == nvm_pkg::ST_WORD) ? nvm_pkg::ST_ACK_WORD :
                          nvm_pkg::ST_ACK_DATA;
            end
          end
        end
        nvm_pkg::ST_ACK_DEV: begin
          if (scl_fall) begin
            if (rw_r) begin
              state_r   <= nvm_pkg::ST_RDATA;
              sda_oe_r  <= ~mem_rdata[DW-1]; // [R4] [R5]
              bit_cnt_r <= 4'h1;
            end else begin
              state_r  <= nvm_pkg::ST_WORD; // [R12]
              sda_oe_r <= 1'b0;
            end
          end
        end
        nvm_pkg::ST_ACK_WORD, nvm_pkg::ST_ACK_DATA: begin
          if (scl_fall) begin
            state_r  <= nvm_pkg::ST_WDATA;
            sda_oe_r <= 1'b0;
          end
        end
        nvm_pkg::ST_RDATA: begin
          if (tx_end) begin
            state_r   <= nvm_pkg::ST_RACK;
            sda_oe_r  <= 1'b0;
            bit_cnt_r <= 4'h0;
          end else if (scl_fall) begin
            sda_oe_r  <= ~tx_r[DW-2]; // [R4] [R5]
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        nvm_pkg::ST_RACK: begin
          if (scl_fall) begin
            if (ack_r) begin
              state_r   <= nvm_pkg::ST_RDATA; // [R14]
              sda_oe_r  <= ~mem_rdata[DW-1];
              bit_cnt_r <= 4'h1;
            end else begin
              state_r <= nvm_pkg::ST_IDLE; // [R14]
            end
          end
        end
        default: begin
          state_r <= nvm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // receive shift, taken on rising clock edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_r <= '0;
    end else if (rx_state && scl_rise && bit_cnt_r != nvm_pkg::BYTE_BITS) begin
      rx_r <= {rx_r[DW-2:0], sda_s}; // [R4]
    end
  end

  // transmit shift, advanced on falling clock edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_r <= '0;
    end else if (tx_load) begin
      tx_r <= mem_rdata;
    end else if (state_r == nvm_pkg::ST_RDATA && scl_fall && !tx_end) begin
      tx_r <= {tx_r[DW-2:0], 1'b0}; // [R4]
    end
  end

  // controller acknowledge taken on the ninth rising edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else if (state_r == nvm_pkg::ST_RACK && scl_rise) begin
      ack_r <= ~sda_s; // [R14]
    end
  end

  // direction flag and address latch
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rw_r   <= 1'b0;
      addr_r <= '0;
    end else if (rx_end && state_r == nvm_pkg::ST_ADDR && dev_hit) begin
      rw_r <= rx_r[nvm_pkg::RW_BIT]; // [R11]
      addr_r[AW-1:nvm_pkg::PAGE_LSB] <= rx_r[nvm_pkg::PAGE_HI:nvm_pkg::PAGE_LO]; // [R11]
    end else if (rx_end && state_r == nvm_pkg::ST_WORD) begin
      addr_r[nvm_pkg::PAGE_LSB-1:0] <= rx_r; // [R12]
    end else if ((rx_end && state_r == nvm_pkg::ST_WDATA) || tx_end) begin
      addr_r <= nvm_pkg::addr_inc(addr_r); // [R13] [R9]
    end
  end

  // the line is only ever pulled low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sda_o_r <= 1'b0;
    end else begin
      sda_o_r <= 1'b0; // [R5]
    end
  end

  // array written at the old address as the address steps [R1]
  byte_array #(
    .DEPTH (MEM_DEPTH),
    .WIDTH (DW)
  ) u_array (
    .clk   (core_clk),
    .we    (wr_commit),
    .waddr (addr_r),
    .wdata (rx_r),
    .raddr (addr_r),
    .rdata (mem_rdata)
  );

  // count of bytes committed to the array
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (wr_commit) begin
      cnt_r <= cnt_r + {{(nvm_pkg::CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // -----------------------------------------------------------------
  // apb slave
  // -----------------------------------------------------------------
  function automatic logic reg_mapped(input logic [11:0] a);
    return (a == nvm_pkg::OFS_CTRL) || (a == nvm_pkg::OFS_STATUS) ||
           (a == nvm_pkg::OFS_COUNT);
  endfunction

  // status word from engine state
  always_comb begin
    status_w = '0;
    status_w[nvm_pkg::ST_BUSY] = (state_r != nvm_pkg::ST_IDLE);
    status_w[nvm_pkg::ST_WP]   = wp_eff;
    status_w[nvm_pkg::ST_RW]   = rw_r;
    status_w[nvm_pkg::ST_ADDR_LSB +: AW] = addr_r;
  end

  // zero-wait answer, read data and error prepared in the setup cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~reg_mapped(paddr);
      if (psel && !penable) begin
        if (pwrite) begin
          prdata_r <= '0;
        end else if (paddr == nvm_pkg::OFS_CTRL) begin
          prdata_r <= {30'h0, ctrl_r};
        end else if (paddr == nvm_pkg::OFS_STATUS) begin
          prdata_r <= status_w;
        end else if (paddr == nvm_pkg::OFS_COUNT) begin
          prdata_r <= {{(32-nvm_pkg::CNT_W){1'b0}}, cnt_r};
        end else begin
          prdata_r <= '0;
        end
      end
    end
  end

  // control register write at the completing edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= nvm_pkg::CTRL_RESET;
    end else if (psel && penable && pready_r && pwrite && paddr == nvm_pkg::OFS_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign sda_o   = sda_o_r;
  assign sda_oe  = sda_oe_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  chk_protect_blocks: assert property ( // [R6]
    @(posedge core_clk) disable iff (rst) (wp_s && rx_end) |-> !wr_commit
  ) else $error("array written while protected");

  chk_commit_counted: assert property ( // [R2] [R7]
    @(posedge core_clk) disable iff (rst)
    (rx_end && state_r == nvm_pkg::ST_WDATA && !wp_eff)
      |=> cnt_r == $past(cnt_r) + 16'h0001
  ) else $error("received byte not committed");

  chk_protected_ack: assert property ( // [R9]
    @(posedge core_clk) disable iff (rst)
    (rx_end && state_r == nvm_pkg::ST_WDATA && wp_eff && !start_det && !stop_det)
      |=> sda_oe_r && state_r == nvm_pkg::ST_ACK_DATA && cnt_r == $past(cnt_r)
  ) else $error("protected byte not acknowledged or counted");

  chk_oe_on_fall: assert property ( // [R4]
    @(posedge core_clk) disable iff (rst)
    $changed(sda_oe_r) |-> $past(scl_fall) || $past(start_det) || $past(stop_det)
  ) else $error("data line changed away from a falling clock");

  chk_rx_on_rise: assert property ( // [R4]
    @(posedge core_clk) disable iff (rst) $changed(rx_r) |-> $past(scl_rise)
  ) else $error("data sampled away from a rising clock");

  chk_open_drain: assert property ( // [R5]
    @(posedge core_clk) disable iff (rst) sda_oe_r |-> !sda_o_r
  ) else $error("data line driven high");

  chk_reset_idle: assert property ( // [R10]
    @(posedge core_clk) $fell(rst) |-> state_r == nvm_pkg::ST_IDLE && !sda_oe_r
  ) else $error("engine not idle after reset");

  chk_start_ready: assert property ( // [R3]
    @(posedge core_clk) disable iff (rst)
    start_det |=> state_r == nvm_pkg::ST_ADDR && bit_cnt_r == 4'h0 && !sda_oe_r
  ) else $error("start condition not taken");

  chk_page_latch: assert property ( // [R11]
    @(posedge core_clk) disable iff (rst)
    (rx_end && state_r == nvm_pkg::ST_ADDR && dev_hit && !start_det && !stop_det)
      |=> addr_r[10:8] == $past(rx_r[3:1]) && rw_r == $past(rx_r[0])
  ) else $error("page or direction not latched");

  chk_word_latch: assert property ( // [R12]
    @(posedge core_clk) disable iff (rst)
    (rx_end && state_r == nvm_pkg::ST_WORD)
      |=> addr_r == {$past(addr_r[10:8]), $past(rx_r)}
  ) else $error("word address not latched");

  chk_addr_step: assert property ( // [R13]
    @(posedge core_clk) disable iff (rst)
    ((rx_end && state_r == nvm_pkg::ST_WDATA) || tx_end)
      |=> addr_r == nvm_pkg::addr_inc($past(addr_r))
  ) else $error("address did not step before acknowledge");

  chk_read_end: assert property ( // [R14]
    @(posedge core_clk) disable iff (rst)
    (state_r == nvm_pkg::ST_RACK && scl_fall && !ack_r && !start_det && !stop_det)
      |=> state_r == nvm_pkg::ST_IDLE ##1 !sda_oe_r
  ) else $error("read continued without acknowledge");

  chk_first_bit: assert property ( // [R4]
    @(posedge core_clk) disable iff (rst)
    (tx_load && !start_det && !stop_det) |=> sda_oe_r == !$past(mem_rdata[7])
  ) else $error("first read bit wrong");
endmodule // nvm_i2c_target

// [logic/nvm_pkg.sv]
// Notes on behaviour
// (R1) The array holds 2,048 bytes of eight bits, each one reachable from the serial bus.
// (R2) A received data byte is written to the array the moment its eighth bit is in.
// (R3) A new transaction may start right after a write, with no completion polling.
// (R4) Outgoing bits change after a falling clock edge; incoming bits are taken on rising edges.
// (R5) The data line is only pulled low or released, never driven high.
// (R6) With write protect high no array location may change, over the whole range.
// (R7) With write protect low every location is writable; the pin idles low when left open (here wp only resets low, no pull-down).
// (R8) Serial clocks up to 1 MHz, and 100 kHz or 400 kHz timing, all work.
// (R9) A protected write is still acknowledged per byte, its data dropped, the address advanced.
// (R10) Reset sends the serial engine back to idle, waiting for a start condition.
// (R11) The first byte holds a type code in bits 7-4, a page in bits 3-1 and read flag in bit 0.
// (R12) A write sends a word address that joins the page into an 11-bit address; a read does not.
// (R13) The address steps just before each data acknowledge and wraps from the top to zero.
// (R14) A read sends bytes while the controller acknowledges; a missing acknowledge ends it.
package nvm_pkg;

  // -----------------------------------------------------------------
  // array and serial framing
  // -----------------------------------------------------------------
  localparam int             MEM_DEPTH    = 2048;
  localparam int             ADDR_W       = 11;
  localparam int             DATA_W       = 8;
  localparam int             PAGE_LSB     = 8;
  localparam int             TYPE_LSB     = 4;
  localparam int             PAGE_HI      = 3;
  localparam int             PAGE_LO      = 1;
  localparam int             RW_BIT       = 0;
  localparam logic [3:0]     BYTE_BITS    = 4'h8;
  localparam logic [3:0]     DEV_TYPE_DEF = 4'h5; // arbitrary value

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int             CORE_PERIOD_NS    = 10;
  localparam int             SCL_MIN_PERIOD_NS = 1000;
  localparam int             SCL_MIN_CYC       = SCL_MIN_PERIOD_NS / CORE_PERIOD_NS;
  localparam int             SCL_NEED_CYC      = 16;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam int             APB_AW      = 12;
  localparam logic [11:0]    OFS_CTRL    = 12'h000;
  localparam logic [11:0]    OFS_STATUS  = 12'h004;
  localparam logic [11:0]    OFS_COUNT   = 12'h008;
  localparam int             CTRL_EN     = 0;
  localparam int             CTRL_SWP    = 1;
  localparam logic [1:0]     CTRL_RESET  = 2'h1;
  localparam int             ST_BUSY     = 0;
  localparam int             ST_WP       = 1;
  localparam int             ST_RW       = 2;
  localparam int             ST_ADDR_LSB = 16;
  localparam int             CNT_W       = 16;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ACK_DEV  = 4'b0010,
    ST_WORD     = 4'b0011,
    ST_ACK_WORD = 4'b0100,
    ST_WDATA    = 4'b0101,
    ST_ACK_DATA = 4'b0110,
    ST_RDATA    = 4'b0111,
    ST_RACK     = 4'b1000
  } state_e;

  // next array address, rolling over at the top
  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    return a + {{(ADDR_W-1){1'b0}}, 1'b1};
  endfunction

endpackage

// [logic/bit_sync.sv]
`timescale 1ns/100ps
// two-stage synchroniser for pin levels
module bit_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule // bit_sync

// [logic/byte_array.sv]
`timescale 1ns/100ps
// flip-flop byte store, one write port, one read port
module byte_array #(
  parameter int DEPTH = nvm_pkg::MEM_DEPTH,
  parameter int WIDTH = nvm_pkg::DATA_W
) (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  if (DEPTH < 2) begin : g_bad_depth
    $error("byte_array depth too small");
  end

  // contents survive reset, as a nonvolatile store does
  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  assign rdata = mem_r[raddr];
endmodule // byte_array

// [dv/i2c_ctrl_model.sv]
`timescale 1ns/100ps
// ---------------------------------------------------------------
// bus controller model, timed from the link clock
// ---------------------------------------------------------------
module i2c_ctrl_model (
  input  wire logic link_clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_low
);
  int         half = 17;  // link clocks per scl phase, just under 1 mhz
  logic [7:0] rx;
  event       rx_ev;

  // bus idles released with scl standing high
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // wait a number of link clocks
  task automatic wt(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_low <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(half);
    sda_low <= 1'b1;
    wt(half);
    scl <= 1'b0;
  endtask

  // stop: sda rises while scl is high, then scl stands still
  task automatic stop();
    wt(2);
    sda_low <= 1'b1;
    wt(half);
    scl <= 1'b1;
    wt(half);
    sda_low <= 1'b0;
    wt(half);
  endtask

  // one clock: sda moves 60 ns into the low phase, wire sampled mid high
  task automatic bit_x(input logic b, output logic r);
    wt(2);
    sda_low <= ~b;
    wt(half - 2);
    scl <= 1'b1;
    wt(half / 2);
    r = sda_w;
    wt(half - half / 2);
    scl <= 1'b0;
  endtask

  // byte out msb first, then the acknowledge slot
  task automatic send(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, nack);
  endtask

  // byte in, acknowledged unless it is the last one
  task automatic recv(input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, rx[i]);
    -> rx_ev;
    bit_x(~ack, r);
  endtask
endmodule // i2c_ctrl_model

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  localparam logic [3:0] DEV = nvm_pkg::DEV_TYPE_DEF;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [11:0] paddr    = 12'h000;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] pwdata   = 32'h0;
  logic        wp_i     = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl;
  logic        sda_low;
  logic        sda_o;
  logic        sda_oe;
  logic        nk;
  logic [32:0] apb_q[$];
  logic [7:0]  byte_q[$];
  logic [7:0]  mem[0:2047];
  int          error_cnt  = 0;
  int          n_compared = 0;
  wire         sda_w = ~(sda_oe | sda_low);  // pull-up, either side pulls low

  // ---------------------------------------------------------------
  // clocks and instances
  // ---------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  // link clock, 30 ns, offset from the core clock
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  nvm_i2c_target u_nvm_i2c_target (.core_clk(core_clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .wp_i(wp_i));
  i2c_ctrl_model u_i2c_ctrl_model (.link_clk(link_clk), .sda_w(sda_w), .scl(scl),
    .sda_low(sda_low));

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchers take the oldest note when a result appears
  always @(posedge core_clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("apb_rd", apb_q.pop_front(), {pslverr, prdata});
  always @(u_i2c_ctrl_model.rx_ev)
    chk("rd_byte", {25'h0, byte_q.pop_front()}, {25'h0, u_i2c_ctrl_model.rx});
  // the device may only move the data line while scl is low
  always @(sda_oe)
    if (scl === 1'b1 && !rst) chk("oe_scl_high", 33'h0, 33'h1);

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    if (!w) apb_q.push_back(e);
    @(posedge core_clk);
    penable <= 1'b1;
    // access phase holds until pready is seen high at a rising edge
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // start, device byte for a write, word address
  task automatic addr(input logic [10:0] a);
    u_i2c_ctrl_model.start();
    u_i2c_ctrl_model.send({DEV, a[10:8], 1'b0}, nk);
    chk("ack_dev", 33'h0, {32'h0, nk});
    u_i2c_ctrl_model.send(a[7:0], nk);
    chk("ack_word", 33'h0, {32'h0, nk});
  endtask

  task automatic wr(input logic [10:0] a, input int n, input logic prot);
    logic [7:0] d;
    addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      u_i2c_ctrl_model.send(d, nk);
      chk("ack_data", 33'h0, {32'h0, nk});
      if (!prot) mem[a] = d;
      a = a + 11'h1;
    end
    u_i2c_ctrl_model.stop();
  endtask

  task automatic rd(input logic [10:0] a, input int n);
    addr(a);
    u_i2c_ctrl_model.start();
    u_i2c_ctrl_model.send({DEV, a[10:8], 1'b1}, nk);
    chk("ack_rd", 33'h0, {32'h0, nk});
    for (int i = 0; i < n; i++) begin
      byte_q.push_back(mem[a]);
      a = a + 11'h1;
      u_i2c_ctrl_model.recv(i != n - 1);
      chk("sda_o", 33'h0, {32'h0, sda_o});
    end
    u_i2c_ctrl_model.stop();
  endtask

  // a lone device byte that must go unanswered
  task automatic probe(input logic [7:0] b);
    u_i2c_ctrl_model.start();
    u_i2c_ctrl_model.send(b, nk);
    chk("nack", 33'h1, {32'h0, nk});
    u_i2c_ctrl_model.stop();
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h05ef4d32));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    apb(12'h000, 1'b0, 32'h0, 33'h1);
    apb(12'h008, 1'b0, 32'h0, 33'h0);
    apb(12'h00c, 1'b0, 32'h0, {1'b1, 32'h0});
    wr(11'h123, 4, 1'b0);
    rd(11'h123, 4);
    apb(12'h004, 1'b0, 32'h0, {1'b0, 32'h0127_0004});
    apb(12'h008, 1'b0, 32'h0, 33'h4);
    wr(11'h7ff, 2, 1'b0);
    rd(11'h7ff, 2);
    @(posedge core_clk);
    wp_i <= 1'b1;
    wr(11'h123, 1, 1'b1);
    apb(12'h004, 1'b0, 32'h0, {1'b0, 32'h0124_0002});
    @(posedge core_clk);
    wp_i <= 1'b0;
    rd(11'h123, 1);
    apb(12'h008, 1'b0, 32'h0, 33'h6);
    apb(12'h000, 1'b1, 32'h3, 33'h0);
    apb(12'h004, 1'b0, 32'h0, {1'b0, 32'h0124_0006});
    apb(12'h000, 1'b1, 32'h1, 33'h0);
    u_i2c_ctrl_model.half = 42;
    rd(11'h000, 1);
    u_i2c_ctrl_model.half = 167;
    probe({DEV ^ 4'h1, 4'h0});
    u_i2c_ctrl_model.half = 17;
    apb(12'h000, 1'b1, 32'h0, 33'h0);
    probe({DEV, 4'h0});
    apb(12'h000, 1'b1, 32'h1, 33'h0);
    u_i2c_ctrl_model.start();
    u_i2c_ctrl_model.send({DEV, 4'h0}, nk);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    apb(12'h004, 1'b0, 32'h0, 33'h0);
    apb(12'h008, 1'b0, 32'h0, 33'h0);
    u_i2c_ctrl_model.stop();
    report_and_stop();
  end

  // watchdog well past the expected run of about 0.5 ms
  initial begin
    #1_000_000;
    error_cnt++;
    report_and_stop();
  end
endmodule // tb_top
